// *** ecbc_pkg.sv ***
// Notes on behaviour
// - writing one to bit 31 of the command register starts the selected operation.
// - busy stays set while running, self-clears; after a read the data is valid.
// - a write with no EEPROM stays busy until timeout, then busy clears.
// - busy reads one right after power-up or any reset.
// - after reset the station address load runs; busy clears when it ends.
package ecbc_pkg;
    localparam logic [7:0]  CMD_OFS      = 8'hB0;
    localparam logic [7:0]  DATA_OFS     = 8'hB4;
    localparam logic [7:0]  STAT_OFS     = 8'hB8;
    localparam logic [7:0]  MASK_OFS     = 8'hBC;
    localparam int          BUSY_BIT     = 31;
    localparam int          CODE_LSB     = 28;
    localparam int          CODE_W       = 3;
    localparam int          TOUT_BIT     = 9;
    localparam int          ADDR_LSB     = 0;
    localparam logic [2:0]  CODE_READ    = 3'h0;
    localparam logic [2:0]  CODE_RESET   = 3'h0;
    localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
    localparam int          EV_DONE      = 0;
    localparam int          EV_TOUT      = 1;
    localparam int          EV_W         = 2;
    localparam int          CLK_MHZ      = 125;
    localparam int          TIMEOUT_US   = 30;
    localparam int          TIMEOUT_CYC  = TIMEOUT_US * CLK_MHZ;
    localparam int          TIMER_W      = 12;

    typedef struct packed {
        logic                is_load;
        logic [CODE_W-1:0]   code;
        logic [7:0]          addr;
        logic [7:0]          wdata;
    } ecbc_op_t;

    typedef enum logic [1:0] {S_LOAD, S_BUSY, S_IDLE} ecbc_state_t;
endpackage : ecbc_pkg

// *** ecbc_timer.sv ***
`timescale 1ns/1ns
module ecbc_timer
    import ecbc_pkg::*;
#(
    parameter int CYC = TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // control
    input  wire logic run,
    output logic      expire
);
    logic [TIMER_W-1:0] cnt_reg;
    logic [TIMER_W-1:0] cnt_next;

    always_comb begin
        cnt_next = '0;
        if (run && cnt_reg != TIMER_W'(CYC - 1)) begin
            cnt_next = cnt_reg + TIMER_W'(1);
        end
    end

    // one-cycle pulse in the last cycle of the window
    assign expire = run && (cnt_reg == TIMER_W'(CYC - 1));

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : ecbc_timer

// *** ecbc_ctrl.sv ***
`timescale 1ns/1ns
module ecbc_ctrl
    import ecbc_pkg::*;
#(
    parameter int TOUT_CYC = TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // operation port to the serial engine
    output logic             op_start,
    output ecbc_op_t         op_req,
    input  wire logic        op_done,
    input  wire logic [7:0]  op_rdata,
    // interrupt
    output logic             irq
);
    ecbc_state_t       state_reg,  state_next;
    ecbc_op_t          req_reg,    req_next;
    logic              start_reg,  start_next;
    logic              tout_reg,   tout_next;
    logic [7:0]        data_reg,   data_next;
    logic [31:0]       rdata_reg,  rdata_next;
    logic [EV_W-1:0]   stat_reg,   stat_next;
    logic [EV_W-1:0]   mask_reg,   mask_next;
    logic              irq_reg,    irq_next;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   w1c;
    logic              busy;
    logic              expire;
    logic              cmd_go;

    assign busy   = (state_reg != S_IDLE);
    assign cmd_go = reg_wr && reg_addr == CMD_OFS && reg_wdata[BUSY_BIT];

    // an engine that never answers (no part fitted) is cut off here
    ecbc_timer #(
        .CYC    (TOUT_CYC)
    ) u_timer (
        .clock  (clock),
        .sys_rst(sys_rst),
        .run    (state_reg == S_BUSY),
        .expire (expire)
    );

    always_comb begin
        state_next = state_reg;
        req_next   = req_reg;
        start_next = 1'b0;
        tout_next  = tout_reg;
        data_next  = data_reg;
        ev         = '0;
        unique case (state_reg)
            S_LOAD: begin
                req_next   = '{is_load: 1'b1, code: CODE_READ, addr: 8'h00, wdata: 8'h00};
                start_next = 1'b1;
                state_next = S_BUSY;
            end
            S_BUSY: begin
                if (op_done) begin
                    state_next    = S_IDLE;
                    ev[EV_DONE]   = 1'b1;
                    if (!req_reg.is_load && req_reg.code == CODE_READ) begin
                        data_next = op_rdata;
                    end
                end else if (expire) begin
                    state_next    = S_IDLE;
                    tout_next     = 1'b1;
                    ev[EV_TOUT]   = 1'b1;
                end
            end
            S_IDLE: begin
                if (cmd_go) begin
                    req_next.is_load = 1'b0;
                    req_next.code    = reg_wdata[CODE_LSB +: CODE_W];
                    req_next.addr    = reg_wdata[ADDR_LSB +: 8];
                    req_next.wdata   = data_reg;
                    tout_next        = 1'b0;
                    start_next       = 1'b1;
                    state_next       = S_BUSY;
                end
                if (reg_wr && reg_addr == DATA_OFS) begin
                    data_next = reg_wdata[7:0];
                end
            end
        endcase
        // command and data writes while busy are dropped, the host is expected not to make them; status and mask writes are always taken
        w1c       = (reg_wr && reg_addr == STAT_OFS) ? reg_wdata[EV_W-1:0] : '0;
        stat_next = (stat_reg & ~w1c) | ev;
        mask_next = (reg_wr && reg_addr == MASK_OFS) ? reg_wdata[EV_W-1:0] : mask_reg;
        irq_next  = |(stat_next & mask_next);
        rdata_next = WORD_RESET;
        if (reg_rd) begin
            unique case (reg_addr)
                CMD_OFS: begin
                    rdata_next[BUSY_BIT]                 = busy;
                    rdata_next[CODE_LSB +: CODE_W]       = req_reg.code;
                    rdata_next[TOUT_BIT]                 = tout_reg;
                    rdata_next[ADDR_LSB +: 8]            = req_reg.addr;
                end
                DATA_OFS: rdata_next[7:0]      = data_reg;
                STAT_OFS: rdata_next[EV_W-1:0] = stat_reg;
                MASK_OFS: rdata_next[EV_W-1:0] = mask_reg;
                default:  rdata_next           = WORD_RESET;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg <= S_LOAD;
            req_reg   <= '0;
            start_reg <= 1'b0;
            tout_reg  <= 1'b0;
            data_reg  <= 8'h00;
            rdata_reg <= WORD_RESET;
            stat_reg  <= '0;
            mask_reg  <= '0;
            irq_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            req_reg   <= req_next;
            start_reg <= start_next;
            tout_reg  <= tout_next;
            data_reg  <= data_next;
            rdata_reg <= rdata_next;
            stat_reg  <= stat_next;
            mask_reg  <= mask_next;
            irq_reg   <= irq_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign op_start  = start_reg;
    assign op_req    = req_reg;
    assign irq       = irq_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    chk_busy_after_reset: assert property ($past(sys_rst) |-> busy ##1 busy)
        else $error("busy not set after reset");
    chk_load_after_reset: assert property ($past(sys_rst) |=> op_start && op_req.is_load)
        else $error("startup load not issued");
    chk_cmd_sample: assert property (
        (state_reg == S_IDLE && cmd_go) |=> op_start && !op_req.is_load
            && op_req.code == $past(reg_wdata[30:28]) && op_req.addr == $past(reg_wdata[7:0]))
        else $error("command not started with sampled fields");
    chk_busy_holds: assert property (
        (state_reg == S_BUSY && !op_done && !expire) |=> busy)
        else $error("busy dropped before completion");
    chk_read_data: assert property (
        (state_reg == S_BUSY && op_done && !op_req.is_load && op_req.code == CODE_READ)
            |=> !busy && data_reg == $past(op_rdata))
        else $error("read data not valid when busy clears");
    chk_timeout_clear: assert property (
        (state_reg == S_BUSY && !op_done && expire) |=> !busy && tout_reg ##1 stat_reg[EV_TOUT])
        else $error("timeout did not clear busy");
    chk_start_busy: assert property (
        (state_reg == S_IDLE && cmd_go) |=> busy ##1 busy)
        else $error("command write did not raise busy");
endmodule : ecbc_ctrl

// *** ecbc_engine_model.sv ***
`timescale 1ns/1ns
module ecbc_engine_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // bench control
    input  wire logic [3:0] delay,
    input  wire logic       absent,
    input  wire logic [7:0] rbyte,
    // engine side
    input  wire logic       op_start,
    output logic            op_done,
    output logic      [7:0] op_rdata
);
    int cnt = -1;
    initial op_done = 1'b0;
    initial op_rdata = 8'h00;
    always @(posedge clock) begin
        op_done <= 1'b0;
        // byte is only meaningful beside done, so it toggles otherwise
        op_rdata <= ~op_rdata;
        if (sys_rst) cnt <= -1;
        else if (op_start && !absent) cnt <= delay;
        else if (cnt == 0) begin
            op_done <= 1'b1;
            op_rdata <= rbyte;
            cnt <= -1;
        end else if (cnt > 0) cnt <= cnt - 1;
        // absent part never answers
    end
endmodule : ecbc_engine_model

// *** tb.sv ***
`timescale 1ns/1ns
module tb;
    import ecbc_pkg::*;
    logic        clock, sys_rst, reg_wr, reg_rd, op_start, op_done, irq, absent, pend;
    logic [7:0]  reg_addr, op_rdata, rbyte, a;
    logic [3:0]  delay;
    logic [31:0] reg_wdata, reg_rdata, exp_q[$], msk_q[$];
    ecbc_op_t    op_req;
    int          bad_count = 0, checks_done = 0, cycles = 0;
    ecbc_ctrl #(.TOUT_CYC(20)) uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .op_start(op_start), .op_req(op_req), .op_done(op_done), .op_rdata(op_rdata), .irq(irq));
    ecbc_engine_model eng (.clock(clock), .sys_rst(sys_rst), .delay(delay), .absent(absent),
        .rbyte(rbyte), .op_start(op_start), .op_done(op_done), .op_rdata(op_rdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_sim
    // reads leave a note; a zero mask means poll only
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d, m);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= ad;
        reg_wdata <= d;
        if (!w) begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        @(posedge clock);
    endtask : bus
    task automatic rel(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clock);
    endtask : rel
    task automatic wait_idle;
        logic idle;
        for (int i = 0; i < 60; i++) begin
            bus(1'b0, CMD_OFS, 32'h0, 32'h0);
            rel(0);
            #1 idle = (reg_rdata[BUSY_BIT] === 1'b0);
            @(posedge clock);
            if (idle) break;
        end
        // a poll limit that runs out is a failure, not a silent fall-through
        if (!idle) bad_count++;
    endtask : wait_idle
    task automatic go(input logic [2:0] c, input logic [7:0] ad);
        bus(1'b1, CMD_OFS, {1'b1, c, 20'h0, ad}, 32'h0);
        rel(0);
        #1 chk(op_start, 1'b1);
        chk({op_req.is_load, op_req.code, op_req.addr}, {1'b0, c, ad});
        @(posedge clock);
    endtask : go
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles > 5000) begin
            bad_count++;
            end_sim();
        end
        if (pend && exp_q.size() > 0) begin
            if (msk_q[0] != 0) chk(reg_rdata & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
        pend = reg_rd;
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, absent, pend} = {3'b100, 42'h0};
        delay = 4'hA;
        rbyte = 8'h5A;
        a = 8'h00;
        void'($urandom(32'hF238));
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1 chk({op_start, op_req.is_load}, 2'h3);
        @(posedge clock);
        bus(1'b0, CMD_OFS, 32'h8000_0000, 32'h8000_0000);
        wait_idle();
        bus(1'b0, CMD_OFS, 32'h0, 32'h8000_0000);
        for (int i = 0; i < 6; i++) begin
            a = 8'($urandom);
            rbyte <= 8'($urandom);
            delay <= 4'(1 + $urandom % 8);
            bus(1'b1, MASK_OFS, i % 2, 32'h0);
            go(CODE_READ, a);
            bus(1'b1, DATA_OFS, 32'hFF, 32'h0);
            wait_idle();
            bus(1'b0, DATA_OFS, rbyte, 32'hFF);
            bus(1'b0, CMD_OFS, {24'h0, a}, 32'hFFFF_FFFF);
            bus(1'b0, STAT_OFS, 32'h1, 32'h1);
            rel(1);
            chk(irq, i % 2);
            bus(1'b1, STAT_OFS, 32'h3, 32'h0);
            rel(2);
            chk(irq, 1'b0);
        end
        absent <= 1'b1;
        go(3'h1, 8'h3C);
        repeat (10) @(posedge clock);
        bus(1'b0, CMD_OFS, 32'h9000_003C, 32'hFFFF_FFFF);
        wait_idle();
        bus(1'b0, CMD_OFS, 32'h1000_023C, 32'hFFFF_FFFF);
        bus(1'b0, STAT_OFS, 32'h2, 32'h2);
        bus(1'b0, 8'h40, 32'h0, 32'hFFFF_FFFF);
        rel(3);
        end_sim();
    end
endmodule : tb
